// [include/sfl_cfg.svh]
// constants of the serial flash command block
// assumes one core clock, host link sampled as plain inputs
// How it works
// - id read gives maker byte, two device bytes, seventeen-byte unique id block
// - id bytes shift out: 24-bit identity, length byte, sixteen factory bytes
// - first unique id byte holds factory length 10h
// - factory content bytes are read-only and default to zero
// - id opcode is ignored for the whole of a running write cycle; any opcode decoded in its first 256 core cycles clears the byte mask, skipping unprogrammed bytes
// - id output bits change on falling serial clock edges
// - deselect ends id output; block returns to standby awaiting a command
// - status is readable anytime and repeats while selected
// - busy flag is read-only, set during write cycle, cleared after
// - write latch flag mirrors latch; page write refused while it is zero
// - plain read: opcode, three address bytes, then data on falling edges
// - reads increment address after each byte and wrap to zero
// - read ends on deselect; rejected while a write cycle runs
// - fast read adds one dummy byte; rejected while busy; ends on deselect
// - page write needs latch set, opcode, address, at least one byte
// - page write erases then programs; unaddressed bytes keep contents
// - page write data wraps to page start within the same page
// - past 256 bytes only the last 256 are kept
// - deselect not on a byte boundary discards the page write
// - deselect starts timed cycle, busy held, latch cleared before end
// - protected page or running cycle blocks the page write
// - write-protect low makes first 256 pages read-only
// - all fields shift most significant bit first
// - inputs sampled on rising serial clock edges after select
// - write enable opcode sets the write latch flag
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH
`define SFL_OP_WREN 8'h06
`define SFL_OP_WRDI 8'h04
`define SFL_OP_ID 8'h9F
`define SFL_OP_STAT 8'h05
`define SFL_OP_READ 8'h03
`define SFL_OP_FAST 8'h0B
`define SFL_OP_PW 8'h0A
`define SFL_ST_BUSY 0
`define SFL_ST_WEL 1
`define SFL_CFD_LEN 8'h10
`define SFL_ID_BYTES 5'd20
`define SFL_ADDR_LAST 2'd2
`define SFL_PROT_PAGES 32'd256
`define SFL_PAGE_BYTES 32'd256
`define SFL_CLK_MHZ 250
`define SFL_T_PW_US 11000
`define SFL_MEM_AW 17
`endif

// [include/sfl_pkg.sv]
// types of the serial flash command block
// assumes nothing of its surroundings
package sfl_pkg;
	typedef enum logic [2:0] {
		SFL_CMD = 3'h0,
		SFL_ADDR = 3'h1,
		SFL_DUMMY = 3'h3,
		SFL_OUT = 3'h2,
		SFL_WDATA = 3'h6,
		SFL_HOLD = 3'h7,
		SFL_IGNORE = 3'h5
	} sfl_state_t;
	typedef enum logic [1:0] {
		SFL_M_ID = 2'h0,
		SFL_M_STAT = 2'h1,
		SFL_M_READ = 2'h2
	} sfl_mode_t;
endpackage

// [logic/sfl_dev.sv]
// serial flash command sequencer, device end
// assumes host link pins asynchronous; serial clock far below core clock
`timescale 1ns/1ps
`include "sfl_cfg.svh"
module sfl_dev #(
	parameter int AW = `SFL_MEM_AW,
	parameter int WR_CYC = `SFL_T_PW_US * `SFL_CLK_MHZ,
	parameter logic [7:0] MFR_ID = 8'hA5, // arbitrary value
	parameter logic [7:0] MEM_TYPE = 8'h5A, // arbitrary value
	parameter logic [7:0] MEM_CAP = 8'h3C, // arbitrary value
	parameter logic [127:0] CFD = 128'h0
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic sel_n_i,
	input wire logic sck_i,
	input wire logic serial_in_line_i,
	input wire logic wp_n_i,
	output logic serial_out_line_o,
	output logic serial_out_line_oe_o
);
	import sfl_pkg::*;

	// ****************************************
	// link synchronisers
	// ****************************************
	logic [2:0] sck_s_q;
	logic [2:0] cs_s_q;
	logic [1:0] si_s_q;
	logic [1:0] wp_s_q;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_s_q <= 3'h0;
			cs_s_q <= 3'h7;
			si_s_q <= 2'h0;
			wp_s_q <= 2'h3;
		end else begin
			sck_s_q <= {sck_s_q[1:0], sck_i};
			cs_s_q <= {cs_s_q[1:0], sel_n_i};
			si_s_q <= {si_s_q[0], serial_in_line_i};
			wp_s_q <= {wp_s_q[0], wp_n_i};
		end
	end
	wire sel = ~cs_s_q[1];
	wire cs_rise = cs_s_q[1] & ~cs_s_q[2];
	wire sck_rise = sel & sck_s_q[1] & ~sck_s_q[2];
	wire sck_fall = sel & ~sck_s_q[1] & sck_s_q[2];
	wire si = si_s_q[1];

	// ****************************************
	// state and storage
	// ****************************************
	sfl_state_t st_q;
	sfl_mode_t mode_q;
	logic [7:0] sr_q;
	logic [2:0] bit_q;
	logic [1:0] acnt_q;
	logic [7:0] op_q;
	logic [23:0] ad_q;
	logic [7:0] sh_q;
	logic [2:0] obit_q;
	logic [4:0] idx_q;
	logic sout_q;
	logic wel_q;
	logic busy_q;
	logic got_q;
	logic start_q;
	logic [31:0] tmr_q;
	logic [AW-9:0] pg_q;
	logic [255:0] mask_q;
	logic [7:0] pbuf [256];
	logic [7:0] mem [2**AW];

	initial begin
		for (int i = 0; i < 2**AW; i++) begin
			mem[i] = 8'hFF;
		end
	end

	// ****************************************
	// decode
	// ****************************************
	wire byte_done = sck_rise & (bit_q == 3'h7);
	wire [7:0] byte_in = {sr_q[6:0], si};
	wire [AW-1:0] ma = ad_q[AW-1:0];
	wire [AW-9:0] pg = ma[AW-1:8];
	wire prot = ~wp_s_q[1] & (32'(pg) < `SFL_PROT_PAGES);
	wire [7:0] status = {6'h00, wel_q, busy_q};
	wire pw_ok = (st_q == SFL_WDATA) & (bit_q == 3'h0) & got_q
		& wel_q & ~busy_q & ~prot;
	wire id_byte_sel = idx_q < `SFL_ID_BYTES;

	function automatic logic [7:0] id_byte(input logic [4:0] i);
		logic [7:0] b;
		b = 8'h00;
		case (i)
			5'd0: b = MFR_ID;
			5'd1: b = MEM_TYPE;
			5'd2: b = MEM_CAP;
			5'd3: b = `SFL_CFD_LEN;
			default: b = CFD[(8'(i) - 8'd4) * 8 +: 8];
		endcase
		return b;
	endfunction

	wire [7:0] id_next = id_byte_sel ? id_byte(idx_q) : 8'h00;

	// ****************************************
	// command shifter
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= SFL_CMD;
			mode_q <= SFL_M_STAT;
			sr_q <= 8'h00;
			bit_q <= 3'h0;
			acnt_q <= 2'h0;
			op_q <= 8'h00;
			ad_q <= 24'h000000;
			sh_q <= 8'h00;
			obit_q <= 3'h0;
			idx_q <= 5'h0;
			sout_q <= 1'b0;
			wel_q <= 1'b0;
			got_q <= 1'b0;
			start_q <= 1'b0;
			mask_q <= '0;
		end else begin
			start_q <= 1'b0;
			if (cs_rise) begin
				st_q <= SFL_CMD;
				bit_q <= 3'h0;
				sout_q <= 1'b0;
				if (st_q == SFL_HOLD && op_q == `SFL_OP_WREN) begin
					wel_q <= 1'b1;
				end
				if (st_q == SFL_HOLD && op_q == `SFL_OP_WRDI) begin
					wel_q <= 1'b0;
				end
				if (pw_ok) begin
					start_q <= 1'b1;
					wel_q <= 1'b0;
				end
			end else if (sck_rise) begin
				sr_q <= byte_in;
				bit_q <= bit_q + 3'h1;
				if (st_q == SFL_HOLD) begin
					st_q <= SFL_IGNORE;
				end
				if (byte_done) begin
					case (st_q)
						SFL_CMD: begin
							op_q <= byte_in;
							acnt_q <= 2'h0;
							got_q <= 1'b0;
							mask_q <= '0;
							case (byte_in)
								`SFL_OP_ID: begin
									st_q <= busy_q ? SFL_IGNORE : SFL_OUT;
									mode_q <= SFL_M_ID;
									sh_q <= MFR_ID;
									idx_q <= 5'h1;
									obit_q <= 3'h0;
								end
								`SFL_OP_STAT: begin
									st_q <= SFL_OUT;
									mode_q <= SFL_M_STAT;
									sh_q <= status;
									obit_q <= 3'h0;
								end
								`SFL_OP_READ, `SFL_OP_FAST, `SFL_OP_PW: begin
									st_q <= busy_q ? SFL_IGNORE : SFL_ADDR;
								end
								`SFL_OP_WREN, `SFL_OP_WRDI: begin
									st_q <= SFL_HOLD;
								end
								default: begin
									st_q <= SFL_IGNORE;
								end
							endcase
						end
						SFL_ADDR: begin
							ad_q <= {ad_q[15:0], byte_in};
							acnt_q <= acnt_q + 2'h1;
							if (acnt_q == `SFL_ADDR_LAST) begin
								if (op_q == `SFL_OP_PW) begin
									st_q <= SFL_WDATA;
								end else if (op_q == `SFL_OP_FAST) begin
									st_q <= SFL_DUMMY;
								end else begin
									st_q <= SFL_OUT;
									mode_q <= SFL_M_READ;
									obit_q <= 3'h0;
									sh_q <= mem[{ad_q[AW-9:0], byte_in}];
									ad_q[AW-1:0] <= {ad_q[AW-9:0], byte_in} + 1'b1;
								end
							end
						end
						SFL_DUMMY: begin
							st_q <= SFL_OUT;
							mode_q <= SFL_M_READ;
							obit_q <= 3'h0;
							sh_q <= mem[ma];
							ad_q[AW-1:0] <= ma + 1'b1;
						end
						SFL_WDATA: begin
							got_q <= 1'b1;
							mask_q[ma[7:0]] <= 1'b1;
							ad_q[7:0] <= ad_q[7:0] + 8'h01;
						end
						default: begin
							st_q <= st_q;
						end
					endcase
				end
			end else if (sck_fall && st_q == SFL_OUT) begin
				sout_q <= sh_q[7];
				obit_q <= obit_q + 3'h1;
				if (obit_q == 3'h7) begin
					case (mode_q)
						SFL_M_ID: begin
							sh_q <= id_next;
							if (id_byte_sel) begin
								idx_q <= idx_q + 5'h1;
							end
						end
						SFL_M_STAT: begin
							sh_q <= status;
						end
						default: begin
							sh_q <= mem[ma];
							ad_q[AW-1:0] <= ma + 1'b1;
						end
					endcase
				end else begin
					sh_q <= {sh_q[6:0], 1'b0};
				end
			end
		end
	end

	// page buffer keeps the last byte per slot
	always_ff @(posedge core_clk_i) begin
		if (byte_done && st_q == SFL_WDATA && !cs_rise) begin
			pbuf[ma[7:0]] <= byte_in;
		end
	end

	// ****************************************
	// self-timed page write
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_q <= 1'b0;
			tmr_q <= 32'h0;
			pg_q <= '0;
		end else if (start_q) begin
			busy_q <= 1'b1;
			tmr_q <= 32'h0;
			pg_q <= pg;
		end else if (busy_q) begin
			tmr_q <= tmr_q + 32'h1;
			if (tmr_q == 32'(WR_CYC - 1)) begin
				busy_q <= 1'b0;
			end
		end
	end

	// only addressed bytes change; the rest keep their contents
	// plain always: the array also takes its erased fill at power-up
	always @(posedge core_clk_i) begin
		if (busy_q && tmr_q < `SFL_PAGE_BYTES && mask_q[tmr_q[7:0]]) begin
			mem[{pg_q, tmr_q[7:0]}] <= pbuf[tmr_q[7:0]];
		end
	end

	assign serial_out_line_o = sout_q;
	assign serial_out_line_oe_o = sel & (st_q == SFL_OUT);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_id_busy_reject: assert property (
		st_q == SFL_CMD && byte_done && byte_in == `SFL_OP_ID && busy_q
		&& !cs_rise |=> st_q == SFL_IGNORE && busy_q)
		else $error("id decoded during busy");
	a_read_busy_reject: assert property (
		st_q == SFL_CMD && byte_done && byte_in == `SFL_OP_READ && busy_q
		&& !cs_rise |=> st_q == SFL_IGNORE)
		else $error("read decoded during busy");
	a_pw_no_latch: assert property (
		cs_rise && st_q == SFL_WDATA && !wel_q && !busy_q |=> ##1 !busy_q)
		else $error("page write ran without latch");
	a_busy_hold_start: assert property (
		start_q |=> busy_q [*8] ##1 !wel_q)
		else $error("busy not held after start");
	a_deselect_ends: assert property (
		cs_rise |=> st_q == SFL_CMD ##1 !serial_out_line_oe_o)
		else $error("deselect did not end command");
	a_out_on_fall: assert property (
		!sck_fall && !cs_rise |=> $stable(sout_q))
		else $error("output changed off falling edge");
	a_bad_count_drop: assert property (
		cs_rise && st_q == SFL_WDATA && bit_q != 3'h0 && !busy_q
		|=> ##1 !busy_q)
		else $error("partial byte page write ran");
	a_protect_drop: assert property (
		cs_rise && st_q == SFL_WDATA && prot && !busy_q |=> ##1 !busy_q)
		else $error("protected page written");
	a_page_wrap: assert property (
		byte_done && st_q == SFL_WDATA && !cs_rise
		|=> ad_q[7:0] == $past(ad_q[7:0]) + 8'h01
		&& ad_q[23:8] == $past(ad_q[23:8]))
		else $error("page address left the page");
endmodule // sfl_dev

// [tb/sfl_host.sv]
// host serial master model: drives select, serial clock and data in
// assumes core clock; 20 core cycles per serial clock half period
`timescale 1ns/1ps
module sfl_host (
	input wire logic clk_i,
	input wire logic so_i,
	input wire logic oe_i,
	output logic sel_n_o,
	output logic sck_o,
	output logic si_o
);
	// ********
	// link
	// ********
	initial begin
		sel_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
	end
	task automatic select();
		@(posedge clk_i);
		sel_n_o <= 1'b0;
		repeat (20) @(posedge clk_i);
	endtask
	// bit set while clock low, sampled at its rise
	task automatic xfer(input logic [7:0] tx, input int nb,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < nb; i++) begin
			@(posedge clk_i);
			sck_o <= 1'b0;
			si_o <= tx[7 - i];
			repeat (20) @(posedge clk_i);
			rx = {rx[6:0], oe_i ? so_i : ~rx[0]};
			sck_o <= 1'b1;
			repeat (19) @(posedge clk_i);
		end
	endtask
	// clock parked low first; released data line toggles
	task automatic deselect();
		@(posedge clk_i);
		sck_o <= 1'b0;
		repeat (20) @(posedge clk_i);
		sel_n_o <= 1'b1;
		si_o <= ~si_o;
		repeat (40) @(posedge clk_i);
	endtask
endmodule // sfl_host

// [tb/test_sfl_dev.sv]
// self-checking bench for the serial flash command sequencer
// assumes the host model sfl_host drives the link at 160 ns per bit
`timescale 1ns/1ps
`include "sfl_cfg.svh"
module test_sfl_dev;
	import sfl_pkg::*;
	localparam int WR_CYC = 12000;
	localparam logic [7:0] MFR = 8'hC6; // arbitrary value
	localparam logic [7:0] MTYP = 8'h39; // arbitrary value
	localparam logic [7:0] MCAP = 8'h72; // arbitrary value
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp_n = 1'b1;
	logic sel_n, sck, si, so, oe;
	logic [7:0] rx;
	int miscompares = 0;
	int comparisons = 0;
	always #2 core_clk = ~core_clk;
	sfl_dev #(.WR_CYC(WR_CYC), .MFR_ID(MFR), .MEM_TYPE(MTYP),
		.MEM_CAP(MCAP), .CFD(128'h0)) sfl_dev_i (
		.core_clk_i(core_clk), .rst_n_i(rst_n), .sel_n_i(sel_n),
		.sck_i(sck), .serial_in_line_i(si), .wp_n_i(wp_n),
		.serial_out_line_o(so), .serial_out_line_oe_o(oe));
	sfl_host sfl_host_i (.clk_i(core_clk), .so_i(so), .oe_i(oe),
		.sel_n_o(sel_n), .sck_o(sck), .si_o(si));
	// ********
	// helpers
	// ********
	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] b);
		sfl_host_i.xfer(b, 8, rx);
	endtask
	task automatic cmd(input logic [7:0] op);
		sfl_host_i.select();
		send(op);
		sfl_host_i.deselect();
	endtask
	task automatic op_addr(input logic [7:0] op, input logic [23:0] a);
		sfl_host_i.select();
		send(op);
		send(a[23:16]);
		send(a[15:8]);
		send(a[7:0]);
	endtask
	task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
		op_addr(`SFL_OP_STAT, 24'h000000);
		cmp(rx & mask, exp);
		send(8'h00);
		cmp(rx & mask, exp);
		sfl_host_i.deselect();
	endtask
	task automatic rd(input logic [7:0] op, input logic [23:0] a,
		input logic [7:0] e0, input logic [7:0] e1);
		op_addr(op, a);
		if (op == `SFL_OP_FAST)
			send(8'h00);
		send(8'h00);
		cmp(rx, e0);
		send(8'h00);
		cmp(rx, e1);
		sfl_host_i.deselect();
	endtask
	task automatic wait_idle();
		for (int n = 0; n < 20; n++) begin
			op_addr(`SFL_OP_STAT, 24'h000000);
			sfl_host_i.deselect();
			if (rx[0] === 1'b0)
				return;
		end
		miscompares++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, rx, 8'h00);
		final_report();
	endtask
	task automatic t_ident();
		logic [7:0] exp;
		sfl_host_i.select();
		send(`SFL_OP_ID);
		for (int i = 0; i < 21; i++) begin
			exp = (i == 0) ? MFR : (i == 1) ? MTYP : (i == 2) ? MCAP :
				(i == 3) ? 8'h10 : 8'h00;
			send(8'h00);
			cmp(rx, exp);
		end
		sfl_host_i.deselect();
		sfl_host_i.select();
		send(`SFL_OP_ID);
		send(8'h00);
		sfl_host_i.deselect();
		stat(8'hFF, 8'h00);
		cmd(`SFL_OP_WREN);
		stat(8'hFF, 8'h02);
		cmd(`SFL_OP_WRDI);
		stat(8'hFF, 8'h00);
		$display("test ident done");
	endtask
	task automatic t_write();
		cmd(`SFL_OP_WREN);
		op_addr(`SFL_OP_PW, 24'h01FFFE);
		send(8'hA1);
		send(8'hB2);
		send(8'hC3);
		sfl_host_i.deselect();
		stat(8'hFF, 8'h01);
		sfl_host_i.select();
		send(`SFL_OP_ID);
		send(8'h00);
		cmp({7'h00, oe}, 8'h00);
		sfl_host_i.deselect();
		op_addr(`SFL_OP_READ, 24'h01FFFE);
		send(8'h00);
		cmp({7'h00, oe}, 8'h00);
		sfl_host_i.deselect();
		cmd(`SFL_OP_WREN);
		op_addr(`SFL_OP_PW, 24'h01FF00);
		send(8'h00);
		sfl_host_i.deselect();
		stat(8'h01, 8'h01);
		wait_idle();
		rd(`SFL_OP_READ, 24'h01FFFE, 8'hA1, 8'hB2);
		rd(`SFL_OP_FAST, 24'h01FFFF, 8'hB2, 8'hFF);
		rd(`SFL_OP_READ, 24'h01FF00, 8'hC3, 8'hFF);
		$display("test write done");
	endtask
	task automatic t_refuse();
		@(posedge core_clk);
		wp_n <= 1'b0;
		cmd(`SFL_OP_WREN);
		op_addr(`SFL_OP_PW, 24'h000010);
		send(8'h55);
		sfl_host_i.deselect();
		stat(8'h01, 8'h00);
		@(posedge core_clk);
		wp_n <= 1'b1;
		cmd(`SFL_OP_WREN);
		op_addr(`SFL_OP_PW, 24'h010000);
		send(8'h66);
		sfl_host_i.xfer(8'h77, 4, rx);
		sfl_host_i.deselect();
		stat(8'h01, 8'h00);
		cmd(`SFL_OP_WRDI);
		op_addr(`SFL_OP_PW, 24'h010000);
		send(8'h66);
		sfl_host_i.deselect();
		stat(8'h01, 8'h00);
		rd(`SFL_OP_READ, 24'h00000F, 8'hFF, 8'hFF);
		rd(`SFL_OP_FAST, 24'h010000, 8'hFF, 8'hFF);
		$display("test refuse done");
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_ident();
		t_write();
		t_refuse();
		final_report();
	end
endmodule // test_sfl_dev
